// *** common/config_load_defs.svh ***
`ifndef CONFIG_LOAD_DEFS_SVH
`define CONFIG_LOAD_DEFS_SVH
// ********
// Timing constants of the configuration loader.
// ********
// Core clock period in picoseconds (250 MHz).
`define CLK_PERIOD_PS 4000
// Least init-to-clock delay, ns.
`define ICCK_MIN_NS 500
// Longest init-to-clock delay, ns.
`define ICCK_MAX_NS 4000
// Least delay in core cycles, rounded up.
`define ICCK_MIN_CYC ((`ICCK_MIN_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
// Power-on clock-rate setting.
`define RATE_POWER_ON 7'd1
// Clock-rate setting used when the stream gives a setting that is not accepted.
`define RATE_DEFAULT 7'd6
// Fastest clock-rate setting.
`define RATE_MAX 7'd100
// Setting above which a daisy chain is not allowed (25 MHz).
`define RATE_CHAIN_MAX 7'd25
// Initial address hold, in periods of the initial clock.
`define INIT_ADDR_PERIODS 3'd5
// Width of the flash byte address.
`define FLASH_ADDR_W 26
// Half period of setting 1 in core cycles (about 0.8 MHz).
`define HALF_RATE1 12'd156
// Mode pin codes.
`define MODE_MASTER_SERIAL 3'h0
`define MODE_SPI 3'h1
`define MODE_BPI 3'h2
`define MODE_SLAVE_PAR 3'h6
`define MODE_SLAVE_SERIAL 3'h7
`endif

// *** common/config_load_pkg.sv ***
// ********
// Types of the configuration loader.
// ********
package config_load_pkg;
	// Load path selected at init rising.
	typedef enum logic [4:0] {
		PATH_MSER = 5'h01,
		PATH_SPI = 5'h02,
		PATH_BPI = 5'h04,
		PATH_SPAR = 5'h08,
		PATH_SSER = 5'h10
	} path_e;
	// Sequencer states.
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_WAIT = 4'h2,
		ST_RUN = 4'h4,
		ST_ABORT = 4'h8
	} state_e;
endpackage : config_load_pkg

// *** hdl/config_clock_gen.sv ***
`include "config_load_defs.svh"
`timescale 1ns/10ps
`default_nettype none
// ********
// Master configuration clock divider.
// ********
module config_clock_gen (
	input wire logic clk, // Core clock.
	input wire logic rstn, // Synchronous reset, active low.
	input wire logic run, // Clock runs while high.
	input wire logic [6:0] rate, // Requested clock-rate setting.
	output logic clk_out, // Generated configuration clock.
	output logic rise, // One-cycle pulse at a rising edge.
	output logic fall // One-cycle pulse at a falling edge.
);
	// Half period counter and the half period in force.
	logic [11:0] cnt_ff;
	logic [11:0] half_ff;
	// Half period: scales inversely with the setting.
	function automatic logic [11:0] half_of(input logic [6:0] r);
		logic [11:0] h;
		h = `HALF_RATE1 / {5'h00, r};
		if (h == 12'h000) begin
			h = 12'h001;
		end
		return h;
	endfunction : half_of
	// The divider reloads its half period only at a low-going boundary, so a rate change never chops a period.
	always_ff @(posedge clk) begin
		if (!rstn || !run) begin
			cnt_ff <= 12'h000;
			clk_out <= 1'b0;
			half_ff <= half_of(`RATE_POWER_ON);
		end else if (cnt_ff + 12'h001 >= half_ff) begin
			cnt_ff <= 12'h000;
			clk_out <= !clk_out;
			if (clk_out) begin
				half_ff <= half_of(rate); // RL20
			end
		end else begin
			cnt_ff <= cnt_ff + 12'h001;
		end
	end
	// Edge pulses line up with the toggles.
	always_ff @(posedge clk) begin
		if (!rstn || !run) begin
			rise <= 1'b0;
			fall <= 1'b0;
		end else begin
			rise <= (cnt_ff + 12'h001 >= half_ff) && !clk_out;
			fall <= (cnt_ff + 12'h001 >= half_ff) && clk_out;
		end
	end
endmodule : config_clock_gen
`default_nettype wire

// *** hdl/byte_skid.sv ***
`include "config_load_defs.svh"
`timescale 1ns/10ps
`default_nettype none
// ********
// Two-entry buffer on the configuration data path.
// ********
module byte_skid #(
	parameter int WIDTH = 8 // Word width.
) (
	input wire logic clk, // Core clock.
	input wire logic rstn, // Synchronous reset, active low.
	input wire logic in_valid, // Word offered.
	output logic in_ready, // Room for a word.
	input wire logic [WIDTH-1:0] in_data, // Offered word.
	output logic out_valid, // Word available.
	input wire logic out_ready, // Receiver takes it.
	output logic [WIDTH-1:0] out_data // Oldest word.
);
	initial begin
		if (WIDTH < 1) begin
			$error("byte_skid needs WIDTH of at least one");
		end
	end
	// Storage and occupancy.
	logic [WIDTH-1:0] mem_ff [2];
	logic rd_ff;
	logic wr_ff;
	logic [1:0] cnt_ff;
	logic push;
	logic pop;
	assign push = in_valid && (cnt_ff != 2'd2);
	assign pop = (cnt_ff != 2'd0) && out_ready;
	assign in_ready = (cnt_ff != 2'd2);
	assign out_valid = (cnt_ff != 2'd0);
	assign out_data = mem_ff[rd_ff];
	// Pointers and count move together, so full and empty stay honest.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			rd_ff <= 1'b0;
			wr_ff <= 1'b0;
			cnt_ff <= 2'd0;
		end else begin
			if (push) begin
				wr_ff <= !wr_ff;
			end
			if (pop) begin
				rd_ff <= !rd_ff;
			end
			cnt_ff <= cnt_ff + {1'b0, push} - {1'b0, pop};
		end
	end
	// Data array needs no reset.
	always_ff @(posedge clk) begin
		if (push) begin
			mem_ff[wr_ff] <= in_data;
		end
	end
endmodule : byte_skid
`default_nettype wire

// *** hdl/config_load_interface.sv ***
`include "config_load_defs.svh"
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// RL1: Master clock starts at setting one, then switches.
// RL2: Only sixteen settings accepted; six is default.
// RL3: Clock frequency scales roughly with the setting.
// RL4: SPI command output changes after falling edge.
// RL5: Serial and SPI data sampled on rising.
// RL6: Chain output driven after falling edge.
// RL7: Mode and variant pins caught at init rise.
// RL8: First flash address held five initial periods.
// RL9: Flash address after falling, data on rising.
// RL10: Slave parallel captures a byte each rising.
// RL11: Chip select and read/write sampled each rising.
// RL12: Host aborts by toggling read/write under select.
// RL13: Read/write steers byte-bus drivers; host releases.
// RL14: Host pauses by stopping clock, not select.
// RL15: Host slave clock at most 100/80 MHz.
// RL16: Chained serial clock at most 25 MHz.
// RL17: Flash must keep up with fastest clock.
// RL18: Master clock starts 0.5 to 4 us after init.
// RL19: Bits shift in msb first; extras forwarded.
// RL20: Divider changes rate only at period boundary.
module config_load_interface #(
	parameter int ICCK_CYC = `ICCK_MIN_CYC, // Init-to-clock delay in core cycles.
	parameter int CONSUME_BITS = 64 // Bits this device keeps before forwarding.
) (
	input wire logic clk, // Core clock, 250 MHz.
	input wire logic rstn, // Synchronous reset, active low.
	input wire logic init_n_pin, // Init signal; loading starts when it rises.
	input wire logic [2:0] mode_pins, // Mode pins.
	input wire logic [2:0] variant_select_pins, // SPI variant select pins.
	input wire logic config_clock_in, // Config clock from a host in slave modes.
	output logic config_clock_out, // Config clock driven in master modes.
	output logic config_clock_oe, // Drive enable for the config clock.
	input wire logic serial_data_in, // Serial data input.
	output logic chain_out, // Daisy-chain output.
	output logic spi_mosi, // SPI command and address output.
	output logic spi_select_n, // SPI flash select, active low.
	input wire logic [7:0] parallel_byte_bus_in, // Byte bus input.
	output logic [7:0] parallel_byte_bus_out, // Byte bus read-back value.
	output logic parallel_byte_bus_oe, // Byte bus drive enable.
	input wire logic chip_select_n, // Slave parallel chip select, active low.
	input wire logic read_write_n, // Read/write select, low for write.
	output logic [`FLASH_ADDR_W-1:0] flash_addr, // Flash byte address.
	output logic [2:0] low_drive_controls, // Flash control outputs, active low.
	output logic high_drive_control, // Flash write control, held high.
	input wire logic [6:0] clock_rate_setting, // Rate option read from the stream.
	input wire logic rate_loaded, // Rate option has been read.
	input wire logic chained, // Several devices in a serial chain.
	output logic rate_error, // Rate option was not an accepted value.
	output logic aborted, // Host aborted a slave parallel load.
	output logic [7:0] cfg_data, // Assembled configuration byte.
	output logic cfg_valid, // Byte available.
	input wire logic cfg_ready, // Consumer takes the byte.
	output logic [2:0] mode_latched, // Mode caught at init rise.
	output logic [2:0] variant_latched // Variant caught at init rise.
);
	initial begin
		if (ICCK_CYC < 1 || CONSUME_BITS < 8) begin
			$error("config_load_interface parameters out of range");
		end
	end
	// ********
	// Synchronisers for every pin.
	// ********
	logic [20:0] s1_ff;
	logic [20:0] s2_ff;
	always_ff @(posedge clk) begin
		if (!rstn) begin
			s1_ff <= 21'h100000;
			s2_ff <= 21'h100000;
		end else begin
			s1_ff <= {init_n_pin, mode_pins, variant_select_pins, config_clock_in, serial_data_in,
				parallel_byte_bus_in, chip_select_n, read_write_n, 2'h0};
			s2_ff <= s1_ff;
		end
	end
	logic init_s;
	logic [2:0] mode_s;
	logic [2:0] var_s;
	logic sclk_s;
	logic din_s;
	logic [7:0] bus_s;
	logic cs_n_s;
	logic rw_n_s;
	assign {init_s, mode_s, var_s, sclk_s, din_s, bus_s, cs_n_s, rw_n_s} = s2_ff[20:2];
	// Edge history; init resets high so a pin held high over a reset starts nothing.
	logic init_d_ff;
	logic sclk_d_ff;
	always_ff @(posedge clk) begin
		if (!rstn) begin
			init_d_ff <= 1'b1;
			sclk_d_ff <= 1'b0;
		end else begin
			init_d_ff <= init_s;
			sclk_d_ff <= sclk_s;
		end
	end
	logic init_rise;
	assign init_rise = init_s && !init_d_ff;
	// ********
	// Mode capture and sequencer.
	// ********
	config_load_pkg::path_e path_ff;
	config_load_pkg::state_e state_ff;
	logic [15:0] wait_ff;
	logic master;
	assign master = (path_ff == config_load_pkg::PATH_MSER) || (path_ff == config_load_pkg::PATH_SPI) ||
		(path_ff == config_load_pkg::PATH_BPI);
	// Mode and variant pins are caught in every mode.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			mode_latched <= 3'h0;
			variant_latched <= 3'h0;
			path_ff <= config_load_pkg::PATH_SSER;
		end else if (init_rise) begin
			mode_latched <= mode_s; // RL7
			variant_latched <= var_s; // RL7
			case (mode_s)
				`MODE_MASTER_SERIAL: path_ff <= config_load_pkg::PATH_MSER;
				`MODE_SPI: path_ff <= config_load_pkg::PATH_SPI;
				`MODE_BPI: path_ff <= config_load_pkg::PATH_BPI;
				`MODE_SLAVE_PAR: path_ff <= config_load_pkg::PATH_SPAR;
				default: path_ff <= config_load_pkg::PATH_SSER;
			endcase
		end
	end
	// Abort detection: read/write moves while chip select stays low.
	logic abort_hit;
	logic rw_ref_ff;
	logic sel_ff;
	assign abort_hit = (path_ff == config_load_pkg::PATH_SPAR) && sel_ff && !cs_n_s && (rw_n_s != rw_ref_ff);
	// Sequencer: wait the init-to-clock delay before a master clock starts.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			state_ff <= config_load_pkg::ST_IDLE;
			wait_ff <= 16'h0000;
		end else begin
			case (state_ff)
				config_load_pkg::ST_IDLE: begin
					if (init_rise) begin
						state_ff <= config_load_pkg::ST_WAIT;
						wait_ff <= 16'h0000;
					end
				end
				config_load_pkg::ST_WAIT: begin
					if (wait_ff + 16'h0001 >= ICCK_CYC[15:0]) begin
						state_ff <= config_load_pkg::ST_RUN; // RL18
					end else begin
						wait_ff <= wait_ff + 16'h0001;
					end
				end
				config_load_pkg::ST_RUN: begin
					if (!init_s) begin
						state_ff <= config_load_pkg::ST_IDLE;
					end else if (abort_hit) begin
						state_ff <= config_load_pkg::ST_ABORT;
					end
				end
				config_load_pkg::ST_ABORT: begin
					if (!init_s) begin
						state_ff <= config_load_pkg::ST_IDLE;
					end
				end
				default: state_ff <= config_load_pkg::ST_IDLE;
			endcase
		end
	end
	// ********
	// Master clock rate choice and generator.
	// ********
	// Accepted settings; anything else falls back to the default.
	function automatic logic rate_ok(input logic [6:0] r);
		case (r)
			7'd1, 7'd3, 7'd6, 7'd7, 7'd8, 7'd10, 7'd12, 7'd13, 7'd17, 7'd22, 7'd25, 7'd27, 7'd33, 7'd44, 7'd50,
			`RATE_MAX: rate_ok = 1'b1; // RL2
			default: rate_ok = 1'b0;
		endcase
	endfunction : rate_ok
	logic [6:0] rate_ff;
	// Power-on setting until the option arrives; chains cap at 25 MHz.
	always_ff @(posedge clk) begin
		if (!rstn || state_ff == config_load_pkg::ST_IDLE) begin
			rate_ff <= `RATE_POWER_ON; // RL1
			rate_error <= 1'b0;
		end else if (rate_loaded) begin
			if (!rate_ok(clock_rate_setting)) begin
				rate_ff <= `RATE_DEFAULT; // RL2
				rate_error <= 1'b1;
			end else if (chained && clock_rate_setting > `RATE_CHAIN_MAX) begin
				rate_ff <= `RATE_CHAIN_MAX; // RL16
			end else begin
				rate_ff <= clock_rate_setting; // RL1
			end
		end
	end
	logic gen_clk;
	logic gen_rise;
	logic gen_fall;
	config_clock_gen u_gen (
		.clk(clk),
		.rstn(rstn),
		.run(master && state_ff == config_load_pkg::ST_RUN),
		.rate(rate_ff), // RL3
		.clk_out(gen_clk),
		.rise(gen_rise),
		.fall(gen_fall)
	);
	// Unified edge pulses: own clock in master modes, sampled host clock otherwise.
	logic rise;
	logic fall;
	logic active;
	assign active = (state_ff == config_load_pkg::ST_RUN);
	assign rise = active && (master ? gen_rise : (sclk_s && !sclk_d_ff));
	assign fall = active && (master ? gen_fall : (!sclk_s && sclk_d_ff));
	always_ff @(posedge clk) begin
		if (!rstn) begin
			config_clock_out <= 1'b0;
			config_clock_oe <= 1'b0;
		end else begin
			config_clock_out <= gen_clk;
			config_clock_oe <= master && active; // RL18
		end
	end
	// ********
	// Serial shift, chain forwarding and byte assembly.
	// ********
	logic [7:0] sh_ff;
	logic [2:0] bit_ff;
	logic [15:0] kept_ff;
	logic fwd_bit_ff;
	logic push;
	logic [7:0] push_data;
	logic in_ready;
	logic [2:0] hold_ff;
	logic addr_go_ff;
	logic serial;
	assign serial = (path_ff == config_load_pkg::PATH_MSER) || (path_ff == config_load_pkg::PATH_SSER) ||
		(path_ff == config_load_pkg::PATH_SPI);
	// Msb first; once this device holds its share, later bits go down the chain.
	always_ff @(posedge clk) begin
		if (!rstn || state_ff == config_load_pkg::ST_IDLE) begin
			sh_ff <= 8'h00;
			bit_ff <= 3'd0;
			kept_ff <= 16'h0000;
			fwd_bit_ff <= 1'b0;
		end else if (serial && rise && in_ready) begin
			if (kept_ff < CONSUME_BITS[15:0]) begin
				sh_ff <= {sh_ff[6:0], din_s}; // RL5 RL19
				bit_ff <= bit_ff + 3'd1;
				kept_ff <= kept_ff + 16'h0001;
			end else begin
				fwd_bit_ff <= din_s; // RL19
			end
		end
	end
	// Byte push: serial per eight bits, parallel per qualified rise.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			push <= 1'b0;
			push_data <= 8'h00;
		end else begin
			push <= 1'b0;
			if (serial && rise && in_ready && bit_ff == 3'd7 && kept_ff < CONSUME_BITS[15:0]) begin
				push <= 1'b1;
				push_data <= {sh_ff[6:0], din_s};
			end else if (path_ff == config_load_pkg::PATH_SPAR && rise && !cs_n_s && !rw_n_s) begin
				push <= 1'b1; // RL10 RL11
				push_data <= bus_s; // RL10
			end else if (path_ff == config_load_pkg::PATH_BPI && rise && addr_go_ff) begin
				push <= 1'b1; // RL9
				push_data <= bus_s; // RL9
			end
		end
	end
	// Chain output moves only after falling edges.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			chain_out <= 1'b0;
		end else if (serial && path_ff != config_load_pkg::PATH_SPI && fall) begin
			chain_out <= fwd_bit_ff; // RL6
		end
	end
	// ********
	// Slave parallel select tracking and bus drivers.
	// ********
	// Reference of read/write taken when select first goes low.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			sel_ff <= 1'b0;
			rw_ref_ff <= 1'b0;
			aborted <= 1'b0;
		end else begin
			if (rise) begin
				sel_ff <= !cs_n_s; // RL11
				if (!sel_ff) begin
					rw_ref_ff <= rw_n_s;
				end
			end
			if (abort_hit) begin
				aborted <= 1'b1; // RL12
			end else if (init_rise) begin
				aborted <= 1'b0;
			end
		end
	end
	// Drivers follow read/write; the host must have released the bus.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			parallel_byte_bus_oe <= 1'b0;
			parallel_byte_bus_out <= 8'h00;
		end else begin
			parallel_byte_bus_oe <= (path_ff == config_load_pkg::PATH_SPAR) && rw_n_s && !cs_n_s; // RL13
			parallel_byte_bus_out <= {5'h00, state_ff == config_load_pkg::ST_ABORT, rate_error, active};
		end
	end
	// ********
	// SPI command output and byte-wide flash addressing.
	// ********
	// Fast-read style command, then zero address; the first bit stands before the first rise.
	logic [31:0] cmd_ff;
	always_ff @(posedge clk) begin
		if (!rstn || state_ff != config_load_pkg::ST_RUN) begin
			cmd_ff <= 32'h0B000000;
			spi_mosi <= 1'b0;
			spi_select_n <= 1'b1;
		end else if (path_ff == config_load_pkg::PATH_SPI && (fall || spi_select_n)) begin
			spi_mosi <= cmd_ff[31]; // RL4
			cmd_ff <= {cmd_ff[30:0], 1'b0}; // RL4
			spi_select_n <= 1'b0;
		end
	end
	// First address stands five initial periods, then steps on falls.
	always_ff @(posedge clk) begin
		if (!rstn || state_ff != config_load_pkg::ST_RUN || path_ff != config_load_pkg::PATH_BPI) begin
			flash_addr <= '0;
			hold_ff <= 3'd0;
			addr_go_ff <= 1'b0;
			low_drive_controls <= 3'h7;
			high_drive_control <= 1'b1;
		end else begin
			low_drive_controls <= 3'h0; // RL8
			high_drive_control <= 1'b1; // RL8
			if (fall) begin
				if (hold_ff < `INIT_ADDR_PERIODS) begin
					hold_ff <= hold_ff + 3'd1; // RL8
				end else if (in_ready) begin
					addr_go_ff <= 1'b1;
					if (addr_go_ff) begin
						flash_addr <= flash_addr + 1'b1; // RL9
					end
				end
			end
		end
	end
	// ********
	// Output buffer; a full buffer stalls the shift and address step.
	// ********
	logic bvalid;
	logic [7:0] bdata;
	byte_skid #(.WIDTH(8)) u_buf (
		.clk(clk),
		.rstn(rstn),
		.in_valid(push),
		.in_ready(in_ready),
		.in_data(push_data),
		.out_valid(bvalid),
		.out_ready(!cfg_valid || cfg_ready),
		.out_data(bdata)
	);
	always_ff @(posedge clk) begin
		if (!rstn) begin
			cfg_valid <= 1'b0;
			cfg_data <= 8'h00;
		end else if (!cfg_valid || cfg_ready) begin
			cfg_valid <= bvalid;
			cfg_data <= bdata;
		end
	end
endmodule : config_load_interface
`default_nettype wire

// *** test/config_load_monitor.sv ***
`include "config_load_defs.svh"
`timescale 1ns/10ps
`default_nettype none
// ********
// Port checker of the configuration loader.
// ********
module config_load_monitor (
	input wire logic clk, // Core clock.
	input wire logic rstn, // Reset, active low.
	input wire logic config_clock_out, // Master clock.
	input wire logic config_clock_oe, // Clock drive enable.
	input wire logic chain_out, // Chain output.
	input wire logic spi_mosi, // Command output.
	input wire logic parallel_byte_bus_oe, // Bus drive enable.
	input wire logic read_write_n, // Read or write.
	input wire logic [`FLASH_ADDR_W-1:0] flash_addr, // Flash address.
	input wire logic [2:0] low_drive_controls, // Flash controls.
	input wire logic high_drive_control, // Flash write control.
	input wire logic [7:0] cfg_data, // Byte out.
	input wire logic cfg_valid, // Byte offered.
	input wire logic cfg_ready, // Byte taken.
	input wire logic [2:0] mode_latched // Caught mode.
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	// Write held long enough to cross the pin synchroniser.
	sequence s_write_held;
		!read_write_n [*5];
	endsequence
	// A byte offered while the consumer stalls.
	sequence s_stalled;
		cfg_valid && !cfg_ready;
	endsequence
	chk_hdc_high: assert property (high_drive_control)
		else $error("flash write control not high");
	chk_bus_write: assert property (s_write_held |-> !parallel_byte_bus_oe)
		else $error("byte bus driven during write");
	chk_hold_byte: assert property (s_stalled |=> cfg_valid && $stable(cfg_data))
		else $error("stalled byte dropped or changed");
	chk_oe_master: assert property ($rose(config_clock_oe) |->
		mode_latched inside {`MODE_MASTER_SERIAL, `MODE_SPI, `MODE_BPI})
		else $error("clock driven in a slave mode");
	chk_mosi_fall: assert property ($changed(spi_mosi) |-> !config_clock_out)
		else $error("command bit moved while clock high");
	chk_chain_fall: assert property ($changed(chain_out) |-> !config_clock_out)
		else $error("chain bit moved while clock high");
	chk_ldc_bpi: assert property (low_drive_controls == 3'h0 |-> mode_latched == `MODE_BPI)
		else $error("flash controls asserted outside flash mode");
	chk_addr_fall: assert property ($changed(flash_addr) |-> !config_clock_out)
		else $error("address moved while clock high");
endmodule : config_load_monitor
bind config_load_interface config_load_monitor mon_u (.clk, .rstn, .config_clock_out, .config_clock_oe,
	.chain_out, .spi_mosi, .parallel_byte_bus_oe, .read_write_n, .flash_addr, .low_drive_controls,
	.high_drive_control, .cfg_data, .cfg_valid, .cfg_ready, .mode_latched);
`default_nettype wire

// *** test/load_host_model.sv ***
`timescale 1ns/10ps
`default_nettype none
// ********
// Host and flash stand-in on the far side of the load port.
// ********
module load_host_model (
	input wire logic config_clock_dev, // Clock from the device.
	output logic hclk, // Host clock.
	output logic cs_n, // Chip select, active low.
	output logic rw_n, // Read or write.
	output logic [7:0] bus, // Byte bus.
	output logic sdata // Serial data.
);
	// Quiet state; the host clock rests low outside transfers.
	initial begin
		hclk = 1'b0;
		cs_n = 1'b1;
		rw_n = 1'b0;
		bus = 8'h00;
		sdata = 1'b0;
	end
	// The flash answers at once, so it is never slower than the clock.
	always @(negedge config_clock_dev) begin
		sdata <= ~sdata;
	end
	// One 32 ns period, far below either slave limit.
	task automatic tick();
		#16 hclk = 1'b1;
		#16 hclk = 1'b0;
	endtask : tick
	// Select stays low between bytes; pausing stops the clock instead.
	task automatic put_byte(input logic [7:0] b);
		cs_n = 1'b0;
		rw_n = 1'b0;
		bus = b;
		tick();
		bus = ~b;
	endtask : put_byte
	// Sends a byte on the serial line, top bit first.
	task automatic put_bits(input logic [7:0] b);
		for (int i = 7; i >= 0; i--) begin
			sdata = b[i];
			tick();
		end
		sdata = ~sdata;
	endtask : put_bits
	// Flips direction under select and inverts the byte driven on the bus.
	task automatic abort();
		rw_n = 1'b1;
		bus = ~bus;
		tick();
		tick();
	endtask : abort
	// Drops the select.
	task automatic idle();
		cs_n = 1'b1;
		rw_n = 1'b0;
	endtask : idle
endmodule : load_host_model
`default_nettype wire

// *** test/testbench.sv ***
`include "config_load_defs.svh"
`timescale 1ns/10ps
`default_nettype none
// ********
// Self-checking bench of the configuration loader.
// ********
module testbench;
	logic clk = 1'b0; // Core clock.
	logic rstn = 1'b0; // Reset, active low.
	logic init_n_pin = 1'b0; // Init level.
	logic [2:0] mode_pins = 3'h0; // Mode pins.
	logic [2:0] variant_select_pins = 3'h0; // Variant pins.
	logic [6:0] clock_rate_setting = 7'h00; // Rate option.
	logic rate_loaded = 1'b0; // Rate option strobe.
	logic chained = 1'b0; // Chain present.
	logic cfg_ready = 1'b1; // Consumer ready.
	logic config_clock_in, serial_data_in, chip_select_n, read_write_n;
	logic [7:0] parallel_byte_bus_in, parallel_byte_bus_out, cfg_data;
	logic config_clock_out, config_clock_oe, chain_out, spi_mosi, spi_select_n;
	logic parallel_byte_bus_oe, high_drive_control, rate_error, aborted, cfg_valid;
	logic [`FLASH_ADDR_W-1:0] flash_addr;
	logic [2:0] low_drive_controls, mode_latched, variant_latched;
	logic [31:0] seed = 32'h5B82; // Random state.
	logic [7:0] b; // Byte in flight.
	logic [7:0] exp_q[$]; // Expected bytes.
	int rates[16] = '{1, 3, 6, 7, 8, 10, 12, 13, 17, 22, 25, 27, 33, 44, 50, 100};
	int num_errors = 0;
	int checked = 0;
	int cycles = 0;
	// Short init delay; one byte kept before forwarding.
	config_load_interface #(.ICCK_CYC(4), .CONSUME_BITS(8)) dut_u (.clk, .rstn, .init_n_pin,
		.mode_pins, .variant_select_pins, .config_clock_in, .config_clock_out, .config_clock_oe,
		.serial_data_in, .chain_out, .spi_mosi, .spi_select_n, .parallel_byte_bus_in,
		.parallel_byte_bus_out, .parallel_byte_bus_oe, .chip_select_n, .read_write_n, .flash_addr,
		.low_drive_controls, .high_drive_control, .clock_rate_setting, .rate_loaded, .chained,
		.rate_error, .aborted, .cfg_data, .cfg_valid, .cfg_ready, .mode_latched, .variant_latched);
	load_host_model host_u (.config_clock_dev(config_clock_out), .hclk(config_clock_in), .cs_n(chip_select_n),
		.rw_n(read_write_n), .bus(parallel_byte_bus_in), .sdata(serial_data_in));
	// Core clock, 4 ns period.
	always #2 clk = ~clk;
	// Fixed-seed xorshift source.
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	// Counts and reports one comparison.
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH %s expected %0h seen %0h", what, exp, got);
		end
	endtask : check
	// Prints the verdict and ends the run.
	task automatic stop_test();
		$display("errors %0d checks %0d", num_errors, checked);
		if (num_errors == 0 && checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : stop_test
	// Bounded wait for a level; a miss is a mismatch.
	task automatic wait_sig(ref logic s, input logic v, input int lim);
		int n;
		n = 0;
		while (s !== v && n < lim) begin
			@(negedge clk);
			n++;
		end
		check("wait level", v, s);
	endtask : wait_sig
	// Raises init with random variant pins, then scrambles the pins.
	task automatic start(input logic [2:0] m);
		logic [2:0] v;
		v = 3'(rnd());
		@(negedge clk);
		init_n_pin = 1'b0;
		mode_pins = m;
		variant_select_pins = v;
		repeat (6) @(negedge clk);
		init_n_pin = 1'b1;
		repeat (5) @(negedge clk);
		mode_pins = ~m;
		variant_select_pins = ~v;
		repeat (4) @(negedge clk);
		check("mode_latched", m, mode_latched);
		check("variant_latched", v, variant_latched);
	endtask : start
	// Measures a high phase in cycles; two periods pass first since rates reload only at a fall.
	task automatic half(input int exp);
		int n;
		n = 0;
		repeat (2) begin
			wait_sig(config_clock_out, 1'b0, 400);
			wait_sig(config_clock_out, 1'b1, 400);
		end
		while (config_clock_out === 1'b1 && n < 400) begin
			@(negedge clk);
			n++;
		end
		check("half period", exp, n);
	endtask : half
	// Hands a new rate option to the clock generator.
	task automatic load_rate(input int r);
		clock_rate_setting = 7'(r);
		rate_loaded = 1'b1;
		@(negedge clk);
		rate_loaded = 1'b0;
	endtask : load_rate
	// Cuts a hang short.
	always @(posedge clk) begin
		cycles++;
		if (cycles == 60000) begin
			num_errors++;
			stop_test();
		end
	end
	// Compares each handed-over byte with the oldest note.
	always @(posedge clk) begin
		if (cfg_valid === 1'b1 && cfg_ready === 1'b1) begin
			if (exp_q.size() == 0) check("spare byte", 0, 1);
			else check("cfg_data", exp_q.pop_front(), cfg_data);
		end
	end
	// Main sequence.
	initial begin
		repeat (2) @(negedge clk);
		rstn = 1'b1;
		@(negedge clk);
		check("spi_select_n", 1, spi_select_n);
		check("low_drive_controls", 7, low_drive_controls);
		// Slave parallel bytes with a stalling consumer.
		start(`MODE_SLAVE_PAR);
		for (int i = 0; i < 12; i++) begin
			b = 8'(rnd());
			exp_q.push_back(b);
			host_u.put_byte(b);
			cfg_ready = b[7] | i[0];
		end
		cfg_ready = 1'b1;
		repeat (40) @(negedge clk);
		host_u.abort();
		repeat (6) @(negedge clk);
		check("aborted", 1, aborted);
		check("bus_oe", 1, parallel_byte_bus_oe);
		check("status", 8'h04, parallel_byte_bus_out & 8'h04);
		host_u.idle();
		// Slave serial: one byte kept, one forwarded.
		start(`MODE_SLAVE_SERIAL);
		b = 8'(rnd());
		exp_q.push_back(b);
		host_u.put_bits(b);
		host_u.put_bits(8'hA5);
		repeat (40) @(negedge clk);
		check("queue left", 0, exp_q.size());
		check("chain_out", 1, chain_out);
		// SPI: command bits, then every rate; consumer stalled.
		cfg_ready = 1'b0;
		start(`MODE_SPI);
		wait_sig(config_clock_oe, 1'b1, 20);
		for (int i = 7; i >= 0; i--) begin
			wait_sig(config_clock_out, 1'b1, 400);
			check("mosi", 8'h0B >> i & 1, spi_mosi);
			wait_sig(config_clock_out, 1'b0, 400);
		end
		half(156);
		foreach (rates[i]) begin
			load_rate(rates[i]);
			half(156 / rates[i] > 0 ? 156 / rates[i] : 1);
		end
		check("rate_error", 0, rate_error);
		load_rate(5);
		half(26);
		check("rate_error", 1, rate_error);
		chained = 1'b1;
		load_rate(50);
		half(6);
		// Reset in mid-run, then the byte-wide flash path.
		rstn = 1'b0;
		repeat (2) @(negedge clk);
		rstn = 1'b1;
		@(negedge clk);
		check("cfg_valid", 0, cfg_valid);
		start(`MODE_BPI);
		wait_sig(config_clock_oe, 1'b1, 20);
		check("low_drive_controls", 0, low_drive_controls);
		for (int i = 0; i < 7; i++) begin
			wait_sig(config_clock_out, 1'b1, 400);
			wait_sig(config_clock_out, 1'b0, 400);
			if (i == 3) check("first address", 0, flash_addr);
		end
		check("address moved", 1, flash_addr !== 26'h0);
		stop_test();
	end
endmodule : testbench
`default_nettype wire
